// ===== pmrc_cfg.svh
`ifndef PMRC_CFG_SVH
`define PMRC_CFG_SVH

// ***********************************************************
// Reset values and timing counts.
// ***********************************************************
`define PMRC_RST_OUT_EN_RST  1'b1
`define PMRC_CP_EN_RST       1'b0
`define PMRC_SUPV_EN_RST     1'b1
`define PMRC_IRQ_MASK_RST    8'hf7
`define PMRC_USER_IO_PIN_DIR_RST    4'h0
`define PMRC_USER_IO_PIN_PU_RST     4'hf
`define PMRC_ANA_EN_RST      6'h00
`define PMRC_TIMEOUT_NS      1000
`define PMRC_CLK_NS          10
`define PMRC_TIMEOUT_CYC     ((`PMRC_TIMEOUT_NS + `PMRC_CLK_NS - 1) / `PMRC_CLK_NS)
`define PMRC_CNT_W           8
`define PMRC_MASK_CLKRDY_BIT 3

`endif

// ===== pmrc_pkg.sv
package pmrc_pkg;

  // ***********************************************************
  // Shared types.
  // ***********************************************************

  // Pin function per user I/O pin.
  typedef enum logic [1:0] {
    PMRC_FN_GPIO  = 2'b00,
    PMRC_FN_SLEEP = 2'b01,
    PMRC_FN_WAKE  = 2'b10,
    PMRC_FN_RSVD  = 2'b11
  } pmrc_fn_e;

  // Power states.
  typedef enum logic [1:0] {
    PMRC_ST_POR    = 2'b00,
    PMRC_ST_WAIT   = 2'b01,
    PMRC_ST_NORMAL = 2'b10,
    PMRC_ST_SLEEP  = 2'b11
  } pmrc_st_e;

  // Analog block enables, one bit each; no bandgap bit on purpose.
  typedef struct packed {
    logic adc;
    logic pump;
    logic vref;
    logic opamp;
    logic dac;
    logic sw;
  } pmrc_ana_s;

  // Software commands for one cycle.
  typedef struct packed {
    logic sleep_cmd;
    logic normal_cmd;
    logic sleep_request_bit;
  } pmrc_cmd_s;

endpackage : pmrc_pkg

// ===== pmrc_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for a bundle of levels.
module pmrc_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,   // System clock.
  input  wire logic         rst,   // Synchronous reset.
  input  wire logic [W-1:0] d,     // Asynchronous input.
  output logic      [W-1:0] q      // Synchronised output.
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // First stage feeds only the second stage.
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  // Registers both stages.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule : pmrc_sync

// ===== pmrc_edge.sv
`timescale 1ns/1ns
// Rising-edge detector on synchronised levels.
module pmrc_edge #(
  parameter int W = 4
) (
  input  wire logic         clk,   // System clock.
  input  wire logic         rst,   // Synchronous reset.
  input  wire logic [W-1:0] lvl,   // Synchronised level.
  output logic      [W-1:0] rise   // One-cycle rising pulse.
);

  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;
  logic [W-1:0] rise_nxt;

  // Computes the edge from the held and current level.
  always_comb begin
    prev_nxt = lvl;
    rise_nxt = lvl & ~prev_r;
  end

  // Registers the level and the pulse.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= '0;
      rise   <= '0;
    end else begin
      prev_r <= prev_nxt;
      rise   <= rise_nxt;
    end
  end

endmodule : pmrc_edge

// ===== pmrc_power_ctrl.sv
`timescale 1ns/1ns
`include "pmrc_cfg.svh"

// Contract
// - After reset enable supervisor; all user pins inputs with pull-ups.
// - Oscillators on at reset; clock outputs only after supervisor release and timeout.
// - At reset all interrupts masked except fast clock locked.
// - Analog blocks disabled after power-up until software enables them.
// - Sleep powers down all but interface, registers, bandgap, enabled wake/supervisor/osc; sleep zeroes only ana_pwr, charge_pump_on keeps its value.
// - Each analog block has its own enable; bandgap has none.
// - Sleep command write sets the shutdown flag.
// - Sleep pin enters sleep without touching flag; overrides writes and wakes.
// - Writing sleep request bit one sets shutdown flag.
// - Sleep state is pin request OR shutdown flag.
// - Releasing sleep pin with flag clear returns to normal.
// - Normal command with pin released clears flag.
// - Wake pin with sleep pin released ends sleep.
// - Day alarm with sleep pin released ends sleep.
// - Wake event in normal mode only records status.
// - Reset output low on POR, supply trip, watchdog, crystal attach, slow clock unready.
// - Clearing reset-out enable routes low supply to flag instead.
// - Charge pump enable zero disables doubler; pins use external rail.
// - Reset-out enable resets to one.
// - Day alarm flag clears on status read or alarm enable clear.
module pmrc_power_ctrl (
  input  wire logic                 clk,               // 100 MHz system clock.
  input  wire logic                 rst,               // Power-on reset, high.
  input  wire logic [3:0]           user_io_pin,       // User I/O pin levels.
  input  wire pmrc_pkg::pmrc_fn_e   pin_fn [4],        // Function of each pin.
  input  wire logic                 supv_ok,           // Supervisor released (pin domain).
  input  wire logic                 low_supply,        // Low supply detector (pin domain).
  input  wire logic                 wdog_expire,       // Watchdog expired (same domain).
  input  wire logic                 xtal_attach,       // Crystal attaching (same domain).
  input  wire logic                 slow_clk_ready,    // Slow clock ready (pin domain).
  input  wire logic                 fast_clock_locked, // FLL lock event.
  input  wire logic                 day_alarm_match,   // Day alarm match pulse.
  input  wire logic                 day_alarm_enable,  // Day alarm enable.
  input  wire logic                 status_read,       // Completed status read pulse.
  input  wire pmrc_pkg::pmrc_cmd_s  cmd,               // Software commands.
  input  wire logic                 reg_wr,            // Configuration write strobe.
  input  wire logic                 reset_out_enable_wr, // Reset-out enable value.
  input  wire logic                 charge_pump_enable_wr, // Pump enable value.
  input  wire pmrc_pkg::pmrc_ana_s  ana_en_wr,         // Analog enables value.
  output logic                      shutdown_flag,     // Software sleep flag.
  output logic                      sleep_state,       // Device asleep.
  output logic                      osc_en,            // Oscillators enabled.
  output logic                      clk_out_en,        // Fast and slow clock outputs on.
  output logic                      supv_en,           // Supervisor enabled.
  output logic [3:0]                user_io_pin_out_en,       // Pin drive enables.
  output logic [3:0]                user_io_pin_pullup,       // Pin pull-ups.
  output logic [7:0]                irq_mask,          // Interrupt mask, 1 masks.
  output pmrc_pkg::pmrc_ana_s       ana_pwr,           // Effective analog power.
  output logic                      charge_pump_on,    // Pump doubler running.
  output logic                      reset_out_enable,  // Reset-out enable bit.
  output logic                      reset_n_out,       // Reset output, low active.
  output logic                      low_digital_supply_flag, // Low supply status.
  output logic                      day_alarm_flag,    // Day alarm status.
  output logic                      wake_flag          // Wake event status.
);

  // ***********************************************************
  // Input synchronisation.
  // ***********************************************************

  logic [3:0] pin_s;
  logic [2:0] misc_s;
  logic [3:0] pin_rise;

  pmrc_sync #(.W(4)) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   (user_io_pin),
    .q   (pin_s)
  );

  pmrc_sync #(.W(3)) u_misc_sync (
    .clk (clk),
    .rst (rst),
    .d   ({supv_ok, low_supply, slow_clk_ready}),
    .q   (misc_s)
  );

  pmrc_edge #(.W(4)) u_pin_edge (
    .clk  (clk),
    .rst  (rst),
    .lvl  (pin_s),
    .rise (pin_rise)
  );

  // Selects pins that carry a given function.
  function automatic logic [3:0] fn_sel(input pmrc_pkg::pmrc_fn_e f [4],
                                        input pmrc_pkg::pmrc_fn_e want);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 4; i++) begin
      r[i] = (f[i] == want);
    end
    return r;
  endfunction : fn_sel

  logic pin_sleep;
  logic pin_wake;

  // Pin requests from synchronised levels only.
  always_comb begin
    pin_sleep = |(pin_s & fn_sel(pin_fn, pmrc_pkg::PMRC_FN_SLEEP));
    pin_wake  = |(pin_rise & fn_sel(pin_fn, pmrc_pkg::PMRC_FN_WAKE));
  end

  // ***********************************************************
  // Power state machine.
  // ***********************************************************

  pmrc_pkg::pmrc_st_e             st_r, st_nxt;
  logic [`PMRC_CNT_W-1:0]         cnt_r, cnt_nxt;
  logic                           shutdown_flag_nxt;
  logic                           wake_ev;
  logic                           sleep_nxt;

  localparam logic [`PMRC_CNT_W-1:0] TO_CYC = `PMRC_CNT_W'(`PMRC_TIMEOUT_CYC);

  // Next state, shutdown flag and timeout count.
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    shutdown_flag_nxt = shutdown_flag;
    wake_ev  = pin_wake | day_alarm_match;
    if (cmd.sleep_cmd) begin
      shutdown_flag_nxt = 1'b1;
    end
    if (cmd.sleep_request_bit) begin
      shutdown_flag_nxt = 1'b1;
    end
    if (cmd.normal_cmd && !pin_sleep) begin
      shutdown_flag_nxt = 1'b0;
    end
    if (wake_ev && !pin_sleep && st_r == pmrc_pkg::PMRC_ST_SLEEP) begin
      shutdown_flag_nxt = 1'b0;
    end
    sleep_nxt = pin_sleep | shutdown_flag_nxt;
    unique case (st_r)
      pmrc_pkg::PMRC_ST_POR: begin
        if (misc_s[2]) begin
          st_nxt  = pmrc_pkg::PMRC_ST_WAIT;
          cnt_nxt = TO_CYC;
        end
      end
      pmrc_pkg::PMRC_ST_WAIT: begin
        if (!misc_s[2]) begin
          st_nxt = pmrc_pkg::PMRC_ST_POR;
        end else if (cnt_r <= `PMRC_CNT_W'(1)) begin
          st_nxt = sleep_nxt ? pmrc_pkg::PMRC_ST_SLEEP : pmrc_pkg::PMRC_ST_NORMAL;
        end else begin
          cnt_nxt = cnt_r - `PMRC_CNT_W'(1);
        end
      end
      pmrc_pkg::PMRC_ST_NORMAL: begin
        if (sleep_nxt) begin
          st_nxt = pmrc_pkg::PMRC_ST_SLEEP;
        end
      end
      pmrc_pkg::PMRC_ST_SLEEP: begin
        if (!sleep_nxt) begin
          st_nxt = pmrc_pkg::PMRC_ST_NORMAL;
        end
      end
    endcase
  end

  // ***********************************************************
  // Configuration and status.
  // ***********************************************************

  logic                rsten_nxt, cpe_nxt, low_digital_supply_flag_nxt, ald_nxt, wk_nxt;
  pmrc_pkg::pmrc_ana_s ana_r, ana_nxt;
  logic                rstn_nxt;

  // Software bits and sticky flags; a set beats a read clear.
  always_comb begin
    rsten_nxt = reset_out_enable;
    cpe_nxt   = charge_pump_on;
    ana_nxt   = ana_r;
    if (reg_wr) begin
      rsten_nxt = reset_out_enable_wr;
      cpe_nxt   = charge_pump_enable_wr;
      ana_nxt   = ana_en_wr;
    end
    low_digital_supply_flag_nxt = status_read ? 1'b0 : low_digital_supply_flag;
    if (misc_s[1] && !reset_out_enable) begin
      low_digital_supply_flag_nxt = 1'b1;
    end
    ald_nxt = (status_read || !day_alarm_enable) ? 1'b0 : day_alarm_flag;
    if (day_alarm_match && day_alarm_enable) begin
      ald_nxt = 1'b1;
    end
    wk_nxt = status_read ? 1'b0 : wake_flag;
    if (wake_ev) begin
      wk_nxt = 1'b1;
    end
    rstn_nxt = !((misc_s[1] && reset_out_enable) || wdog_expire || xtal_attach ||
                 !misc_s[0]);
  end

  // Registers all state; reset values give the power-on defaults.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r                    <= pmrc_pkg::PMRC_ST_POR;
      cnt_r                   <= '0;
      shutdown_flag           <= 1'b0;
      sleep_state             <= 1'b0;
      osc_en                  <= 1'b1;
      clk_out_en              <= 1'b0;
      supv_en                 <= `PMRC_SUPV_EN_RST;
      user_io_pin_out_en             <= `PMRC_USER_IO_PIN_DIR_RST;
      user_io_pin_pullup             <= `PMRC_USER_IO_PIN_PU_RST;
      irq_mask                <= `PMRC_IRQ_MASK_RST;
      ana_r                   <= `PMRC_ANA_EN_RST;
      ana_pwr                 <= `PMRC_ANA_EN_RST;
      charge_pump_on          <= `PMRC_CP_EN_RST;
      reset_out_enable        <= `PMRC_RST_OUT_EN_RST;
      reset_n_out             <= 1'b0;
      low_digital_supply_flag <= 1'b0;
      day_alarm_flag          <= 1'b0;
      wake_flag               <= 1'b0;
    end else begin
      st_r                    <= st_nxt;
      cnt_r                   <= cnt_nxt;
      shutdown_flag           <= shutdown_flag_nxt;
      sleep_state             <= (st_nxt == pmrc_pkg::PMRC_ST_SLEEP);
      osc_en                  <= 1'b1;
      clk_out_en              <= (st_nxt == pmrc_pkg::PMRC_ST_NORMAL) ||
                                 (st_nxt == pmrc_pkg::PMRC_ST_SLEEP);
      supv_en                 <= supv_en;
      user_io_pin_out_en             <= user_io_pin_out_en;
      user_io_pin_pullup             <= user_io_pin_pullup;
      irq_mask                <= irq_mask;
      ana_r                   <= ana_nxt;
      ana_pwr                 <= (st_nxt == pmrc_pkg::PMRC_ST_NORMAL) ? ana_nxt : '0;
      charge_pump_on          <= cpe_nxt;
      reset_out_enable        <= rsten_nxt;
      reset_n_out             <= rstn_nxt;
      low_digital_supply_flag <= low_digital_supply_flag_nxt;
      day_alarm_flag          <= ald_nxt;
      wake_flag               <= wk_nxt;
    end
  end

  // ***********************************************************
  // Checks.
  // ***********************************************************

  sleep_or_a: assert property (@(posedge clk) disable iff (rst)
    (st_r inside {pmrc_pkg::PMRC_ST_NORMAL, pmrc_pkg::PMRC_ST_SLEEP}) |=>
    (sleep_state == ($past(pin_sleep) | shutdown_flag)))
    else $error("sleep state not pin OR flag");

  sleep_cmd_a: assert property (@(posedge clk) disable iff (rst)
    cmd.sleep_cmd && !cmd.normal_cmd |=> shutdown_flag)
    else $error("sleep command did not set flag");

  req_bit_a: assert property (@(posedge clk) disable iff (rst)
    cmd.sleep_request_bit && !cmd.normal_cmd |=> shutdown_flag)
    else $error("request bit did not set flag");

  pin_keep_a: assert property (@(posedge clk) disable iff (rst)
    pin_sleep && !cmd.sleep_cmd && !cmd.sleep_request_bit |=>
    shutdown_flag == $past(shutdown_flag))
    else $error("pin sleep changed flag");

  normal_cmd_a: assert property (@(posedge clk) disable iff (rst)
    cmd.normal_cmd && !pin_sleep |=> !shutdown_flag)
    else $error("normal command did not clear flag");

  sleep_pwr_a: assert property (@(posedge clk) disable iff (rst)
    sleep_state |-> ana_pwr == '0)
    else $error("analog powered in sleep");

  rst_out_a: assert property (@(posedge clk) disable iff (rst)
    wdog_expire || xtal_attach |=> !reset_n_out)
    else $error("reset output not low");

  alarm_clr_a: assert property (@(posedge clk) disable iff (rst)
    !day_alarm_enable |=> !day_alarm_flag)
    else $error("alarm flag not cleared");

  clk_gate_a: assert property (@(posedge clk) disable iff (rst)
    clk_out_en |-> $past(st_r) != pmrc_pkg::PMRC_ST_POR)
    else $error("clock out before timeout");

  wake_rec_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == pmrc_pkg::PMRC_ST_NORMAL) && wake_ev && !shutdown_flag_nxt && !pin_sleep
    |=> wake_flag && !sleep_state)
    else $error("wake in normal changed state");

endmodule : pmrc_power_ctrl

// ===== pmrc_host_model.sv
`timescale 1ns/1ns
// ***********************************************************
// Host controller model: pins, commands and configuration.
// ***********************************************************
module pmrc_host_model (
  input  wire logic           clk,         // System clock.
  output logic [3:0]          user_io_pin, // Pin levels towards the block.
  output pmrc_pkg::pmrc_cmd_s cmd,         // One-cycle commands.
  output logic                status_read, // Status read pulse.
  output logic                reg_wr,      // Configuration write strobe.
  output logic                roe_wr,      // Reset-out enable value.
  output logic                cp_wr,       // Pump enable value.
  output pmrc_pkg::pmrc_ana_s ana_wr       // Analog enables value.
);
  // Idle levels before the first edge.
  initial begin
    user_io_pin = 4'h0;
    cmd = '0;
    status_read = 1'b0;
    reg_wr = 1'b0;
    roe_wr = 1'b1;
    cp_wr = 1'b0;
    ana_wr = '0;
  end

  // Issues one command for exactly one cycle.
  task pulse_cmd(input pmrc_pkg::pmrc_cmd_s c);
    @(posedge clk) cmd <= c;
    @(posedge clk) cmd <= '0;
  endtask : pulse_cmd

  // Completes one status read.
  task read_status();
    @(posedge clk) status_read <= 1'b1;
    @(posedge clk) status_read <= 1'b0;
  endtask : read_status

  task configure(input logic roe, input logic cp, input pmrc_pkg::pmrc_ana_s ana);
    @(posedge clk) begin
      roe_wr <= roe;
      cp_wr <= cp;
      ana_wr <= ana;
      reg_wr <= 1'b1;
    end
    @(posedge clk) reg_wr <= 1'b0;
  endtask : configure

  // Moves one pin to a new level.
  task set_pin(input int idx, input logic lvl);
    @(posedge clk) user_io_pin[idx] <= lvl;
  endtask : set_pin
endmodule : pmrc_host_model

// ===== power_mode_reset_control_tb_top.sv
`timescale 1ns/1ns
`include "pmrc_cfg.svh"
module power_mode_reset_control_tb_top;
  logic clk, rst, supv_ok, low_supply, wdog_expire, xtal_attach, slow_clk_ready;
  logic fast_clock_locked, day_alarm_match, day_alarm_enable, status_read, reg_wr;
  logic roe_wr, cp_wr, shutdown_flag, sleep_state, osc_en, clk_out_en, supv_en;
  logic charge_pump_on, reset_out_enable, reset_n_out, low_digital_supply_flag;
  logic day_alarm_flag, wake_flag;
  logic [3:0] user_io_pin, user_io_pin_out_en, user_io_pin_pullup;
  logic [7:0] irq_mask;
  pmrc_pkg::pmrc_fn_e pin_fn [4];
  pmrc_pkg::pmrc_cmd_s cmd;
  pmrc_pkg::pmrc_ana_s ana_wr, ana_pwr;
  int err_count, compares, cycles;

  // ***********************************************************
  // Clock, stimulus idle values and instances.
  // ***********************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  pmrc_host_model HOST (.clk(clk), .user_io_pin(user_io_pin), .cmd(cmd),
    .status_read(status_read), .reg_wr(reg_wr), .roe_wr(roe_wr), .cp_wr(cp_wr),
    .ana_wr(ana_wr));

  pmrc_power_ctrl DUT (.clk(clk), .rst(rst), .user_io_pin(user_io_pin), .pin_fn(pin_fn),
    .supv_ok(supv_ok), .low_supply(low_supply), .wdog_expire(wdog_expire),
    .xtal_attach(xtal_attach), .slow_clk_ready(slow_clk_ready),
    .fast_clock_locked(fast_clock_locked), .day_alarm_match(day_alarm_match),
    .day_alarm_enable(day_alarm_enable), .status_read(status_read), .cmd(cmd),
    .reg_wr(reg_wr), .reset_out_enable_wr(roe_wr), .charge_pump_enable_wr(cp_wr),
    .ana_en_wr(ana_wr), .shutdown_flag(shutdown_flag), .sleep_state(sleep_state),
    .osc_en(osc_en), .clk_out_en(clk_out_en), .supv_en(supv_en),
    .user_io_pin_out_en(user_io_pin_out_en), .user_io_pin_pullup(user_io_pin_pullup), .irq_mask(irq_mask),
    .ana_pwr(ana_pwr), .charge_pump_on(charge_pump_on),
    .reset_out_enable(reset_out_enable), .reset_n_out(reset_n_out),
    .low_digital_supply_flag(low_digital_supply_flag),
    .day_alarm_flag(day_alarm_flag), .wake_flag(wake_flag));

  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  // ***********************************************************
  // Shared helpers.
  // ***********************************************************
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task wait_state(input logic v);
    for (int i = 0; i < 8 && sleep_state !== v; i++) tick(1);
  endtask : wait_state

  task wait_rst(input logic v);
    for (int i = 0; i < 150 && reset_n_out !== v; i++) tick(1);
  endtask : wait_rst

  // Raises or drops one reset source; the clock-ready source is inverted.
  task drive_src(input int idx, input logic act);
    @(posedge clk) case (idx)
      0: wdog_expire <= act;
      1: xtal_attach <= act;
      2: low_supply <= act;
      default: slow_clk_ready <= !act;
    endcase
  endtask : drive_src

  task alarm_pulse();
    @(posedge clk) day_alarm_match <= 1'b1;
    @(posedge clk) day_alarm_match <= 1'b0;
    #1;
  endtask : alarm_pulse

  // ***********************************************************
  // Scenarios.
  // ***********************************************************
  task t_reset();
    tick(0);
    check(supv_en, 1'b1);
    check(user_io_pin_out_en, 4'h0);
    check(user_io_pin_pullup, 4'hf);
    check(osc_en, 1'b1);
    check(irq_mask, 8'hf7);
    check(ana_pwr, 6'h00);
    check(reset_out_enable, 1'b1);
    check(reset_n_out, 1'b0);
    check(charge_pump_on, 1'b0);
  endtask : t_reset

  task t_startup();
    tick(150);
    check(clk_out_en, 1'b0);
    // A lock event must leave the power-on mask untouched.
    @(posedge clk) fast_clock_locked <= 1'b1;
    tick(1);
    check(irq_mask, 8'hf7);
    // Two synchroniser edges, one edge into the wait, then the full timeout.
    @(posedge clk) supv_ok <= 1'b1;
    tick(`PMRC_TIMEOUT_CYC + 2);
    check(clk_out_en, 1'b0);
    tick(1);
    check(clk_out_en, 1'b1);
    wait_rst(1'b1);
    check(reset_n_out, 1'b1);
    check(ana_pwr, 6'h00);
  endtask : t_startup

  task t_sw_sleep();
    HOST.configure(1'b1, 1'b0, 6'h15);
    tick(2);
    check(ana_pwr, 6'h15);
    HOST.configure(1'b1, 1'b0, 6'h2a);
    tick(2);
    check(ana_pwr, 6'h2a);
    HOST.pulse_cmd(3'b100);
    #1;
    check(shutdown_flag, 1'b1);
    check(sleep_state, 1'b1);
    check(ana_pwr, 6'h00);
    check(supv_en, 1'b1);
    HOST.pulse_cmd(3'b010);
    #1;
    check(shutdown_flag, 1'b0);
    check(sleep_state, 1'b0);
    check(ana_pwr, 6'h2a);
    HOST.pulse_cmd(3'b001);
    #1;
    check(shutdown_flag, 1'b1);
    check(sleep_state, 1'b1);
    HOST.pulse_cmd(3'b110);
    #1;
    check(shutdown_flag, 1'b0);
  endtask : t_sw_sleep

  task t_pin_sleep();
    HOST.set_pin(0, 1'b1);
    tick(2);
    check(sleep_state, 1'b0);
    wait_state(1'b1);
    check(sleep_state, 1'b1);
    check(shutdown_flag, 1'b0);
    HOST.pulse_cmd(3'b010);
    HOST.set_pin(1, 1'b1);
    tick(5);
    check(sleep_state, 1'b1);
    HOST.set_pin(1, 1'b0);
    HOST.set_pin(0, 1'b0);
    wait_state(1'b0);
    check(sleep_state, 1'b0);
    tick(4);
  endtask : t_pin_sleep

  // Moves the pin functions around; only the pins so configured may act.
  task t_pin_fn();
    @(posedge clk) pin_fn <= '{pmrc_pkg::PMRC_FN_GPIO, pmrc_pkg::PMRC_FN_RSVD,
                               pmrc_pkg::PMRC_FN_SLEEP, pmrc_pkg::PMRC_FN_WAKE};
    HOST.set_pin(0, 1'b1);
    HOST.set_pin(1, 1'b1);
    tick(5);
    check(sleep_state, 1'b0);
    HOST.set_pin(2, 1'b1);
    wait_state(1'b1);
    check(sleep_state, 1'b1);
    check(shutdown_flag, 1'b0);
    HOST.set_pin(2, 1'b0);
    wait_state(1'b0);
    check(sleep_state, 1'b0);
    HOST.pulse_cmd(3'b100);
    #1;
    check(sleep_state, 1'b1);
    HOST.set_pin(3, 1'b1);
    wait_state(1'b0);
    check(sleep_state, 1'b0);
    HOST.set_pin(3, 1'b0);
    HOST.set_pin(0, 1'b0);
    HOST.set_pin(1, 1'b0);
    @(posedge clk) pin_fn <= '{pmrc_pkg::PMRC_FN_SLEEP, pmrc_pkg::PMRC_FN_WAKE,
                               pmrc_pkg::PMRC_FN_GPIO, pmrc_pkg::PMRC_FN_GPIO};
    tick(4);
  endtask : t_pin_fn

  task t_wake();
    HOST.pulse_cmd(3'b100);
    HOST.set_pin(1, 1'b1);
    wait_state(1'b0);
    check(sleep_state, 1'b0);
    HOST.set_pin(1, 1'b0);
    tick(4);
    // Clear the flag left by earlier wakes so the next one must set it.
    HOST.read_status();
    tick(1);
    check(wake_flag, 1'b0);
    HOST.set_pin(1, 1'b1);
    tick(5);
    check(sleep_state, 1'b0);
    check(wake_flag, 1'b1);
    HOST.set_pin(1, 1'b0);
  endtask : t_wake

  task t_alarm();
    @(posedge clk) day_alarm_enable <= 1'b1;
    HOST.pulse_cmd(3'b001);
    alarm_pulse();
    wait_state(1'b0);
    check(sleep_state, 1'b0);
    check(day_alarm_flag, 1'b1);
    HOST.read_status();
    tick(1);
    check(day_alarm_flag, 1'b0);
    alarm_pulse();
    tick(1);
    check(day_alarm_flag, 1'b1);
    check(sleep_state, 1'b0);
    @(posedge clk) day_alarm_enable <= 1'b0;
    tick(2);
    check(day_alarm_flag, 1'b0);
  endtask : t_alarm

  task t_reset_out();
    for (int i = 0; i < 4; i++) begin
      drive_src(i, 1'b1);
      wait_rst(1'b0);
      check(reset_n_out, 1'b0);
      drive_src(i, 1'b0);
      wait_rst(1'b1);
      check(reset_n_out, 1'b1);
    end
    HOST.configure(1'b0, 1'b1, 6'h3f);
    tick(2);
    check(reset_out_enable, 1'b0);
    check(charge_pump_on, 1'b1);
    drive_src(2, 1'b1);
    tick(6);
    check(reset_n_out, 1'b1);
    check(low_digital_supply_flag, 1'b1);
    drive_src(2, 1'b0);
    HOST.configure(1'b1, 1'b0, 6'h3f);
    tick(2);
    check(charge_pump_on, 1'b0);
  endtask : t_reset_out

  task results();
    $display("checks %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // Main sequence: reset, then every scenario in turn.
  initial begin
    err_count = 0;
    compares = 0;
    cycles = 0;
    rst = 1'b1;
    supv_ok = 1'b0;
    low_supply = 1'b0;
    wdog_expire = 1'b0;
    xtal_attach = 1'b0;
    slow_clk_ready = 1'b1;
    fast_clock_locked = 1'b0;
    day_alarm_match = 1'b0;
    day_alarm_enable = 1'b0;
    pin_fn = '{pmrc_pkg::PMRC_FN_SLEEP, pmrc_pkg::PMRC_FN_WAKE,
               pmrc_pkg::PMRC_FN_GPIO, pmrc_pkg::PMRC_FN_GPIO};
    tick(8);
    t_reset();
    @(posedge clk) rst <= 1'b0;
    t_startup();
    t_sw_sleep();
    t_pin_sleep();
    t_pin_fn();
    t_wake();
    t_alarm();
    t_reset_out();
    results();
  end
endmodule : power_mode_reset_control_tb_top
